/* File: sss_downstream_model.sv */
// downstream setpoint consumer sampling both totals
`timescale 1ns/10ps
module sss_downstream_model (
  input  wire logic        clock_i,
  input  wire logic [15:0] total0_i,
  input  wire logic [15:0] total1_i,
  output logic      [15:0] seen0_o,
  output logic      [15:0] seen1_o
);
  always_ff @(posedge clock_i) begin
    seen0_o <= total0_i;
    seen1_o <= total1_i;
  end
endmodule

/* File: sss_sum_unit.sv */
// setpoint sum package and one summing instance datapath
package sss_pkg;
  // values: percent in 0.01 units, ratios and dividers in 0.0001 units
  localparam int unsigned SSS_DW        = 16;
  localparam logic [15:0] SSS_RATIO_RST = 16'h2710; // 1.0000
  localparam logic [15:0] SSS_DIV_RST   = 16'h2710; // 1.0000
  localparam logic [15:0] SSS_LIMIT_RST = 16'h2904; // 105.00 %
  localparam logic [15:0] SSS_LIMIT_MAX = 16'h4e20; // 200.00 %
  localparam logic [1:0]  SSS_SIGN_RST  = 2'h3;     // both positive
  // register word offsets inside one instance window
  localparam logic [5:0]  SSS_OFS_IN0    = 6'h00;
  localparam logic [5:0]  SSS_OFS_IN1    = 6'h04;
  localparam logic [5:0]  SSS_OFS_IN2    = 6'h08;
  localparam logic [5:0]  SSS_OFS_RATIO0 = 6'h0c;
  localparam logic [5:0]  SSS_OFS_RATIO1 = 6'h10;
  localparam logic [5:0]  SSS_OFS_DIV0   = 6'h14;
  localparam logic [5:0]  SSS_OFS_DIV1   = 6'h18;
  localparam logic [5:0]  SSS_OFS_SIGN   = 6'h1c;
  localparam logic [5:0]  SSS_OFS_LIMIT  = 6'h20;
  localparam logic [5:0]  SSS_OFS_TOTAL  = 6'h24;
  localparam logic [5:0]  SSS_OFS_CH0    = 6'h28;
  localparam logic [5:0]  SSS_OFS_CH1    = 6'h2c;
  localparam int unsigned SSS_NUM_INST   = 2;
endpackage

`timescale 1ns/10ps
module sss_sum_unit
  import sss_pkg::*;
#(
  parameter int unsigned DW = SSS_DW
) (
  input  wire logic                 clock_i,
  input  wire logic                 rst_i,
  input  wire logic                 ce_i,
  input  wire logic signed [DW-1:0] in0_i,
  input  wire logic signed [DW-1:0] in1_i,
  input  wire logic signed [DW-1:0] in2_i,
  input  wire logic signed [DW-1:0] ratio0_i,
  input  wire logic signed [DW-1:0] ratio1_i,
  input  wire logic signed [DW-1:0] div0_i,
  input  wire logic signed [DW-1:0] div1_i,
  input  wire logic                 pos0_i,
  input  wire logic                 pos1_i,
  input  wire logic        [DW-1:0] limit_i,
  output logic signed      [DW-1:0] total_o,
  output logic signed      [DW-1:0] ch0_o,
  output logic signed      [DW-1:0] ch1_o
);
  localparam int unsigned WW = 2 * DW + 2;

  // (in x ratio) / div with sign; the 0.0001 scales cancel
  function automatic logic signed [WW-1:0] scale(
    input logic signed [DW-1:0] v,
    input logic signed [DW-1:0] r,
    input logic signed [DW-1:0] d,
    input logic                 pos
  );
    logic signed [WW-1:0] p;
    logic signed [WW-1:0] q;
    p = WW'(v) * WW'(r);
    if (d == '0) begin
      q = '0;
    end else begin
      q = p / WW'(d);
    end
    scale = pos ? q : -q;
  endfunction

  function automatic logic signed [DW-1:0] sat(
    input logic signed [WW-1:0] v,
    input logic        [DW-1:0] lim
  );
    logic signed [WW-1:0] l;
    l = WW'({1'b0, lim});
    if (v > l) begin
      sat = DW'(l);
    end else if (v < -l) begin
      sat = DW'(-l);
    end else begin
      sat = DW'(v);
    end
  endfunction

  logic signed [DW-1:0] c0;
  logic signed [DW-1:0] c1;
  logic signed [WW-1:0] sum;

  always_comb begin
    c0  = sat(scale(in0_i, ratio0_i, div0_i, pos0_i), limit_i);
    c1  = sat(scale(in1_i, ratio1_i, div1_i, pos1_i), limit_i);
    sum = WW'(c0) + WW'(c1) + WW'(in2_i);
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      total_o <= '0;
      ch0_o   <= '0;
      ch1_o   <= '0;
    end else if (ce_i) begin
      total_o <= sat(sum, limit_i);
      ch0_o   <= c0;
      ch1_o   <= c1;
    end
  end
endmodule

/* File: sss_top.sv */
// setpoint sum scaler top: avalon-mm register file and two sum units
//
// Behaviour
// - adds up to three percentage inputs into one setpoint total result.
// - channels 0 and 1 have own multiplier, divider and polarity.
// - scaled channel 0 and 1 results clamp to plus or minus limit.
// - channel 2 is summed directly, no scaling, sign or clamp.
// - summed total is clamped again to plus or minus limit.
// - two independent instances, each with own settings and outputs.
// - each instance outputs both clamped per-channel sub-results.
// - a zero divider makes that channel's division give zero.
// - limit programmable 0 to 200 percent, used for channels and total.
//
// Implementation choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/10ps
module sss_top
  import sss_pkg::*;
#(
  parameter int unsigned DW = SSS_DW
) (
  input  wire logic          clock_i,
  input  wire logic          rst_i,
  input  wire logic          ce_i,
  input  wire logic [6:0]    address_i,
  input  wire logic          read_i,
  input  wire logic          write_i,
  input  wire logic [3:0]    byteenable_i,
  input  wire logic [31:0]   writedata_i,
  output logic      [31:0]   readdata_o,
  output logic               waitrequest_o,
  output logic      [DW-1:0] setpoint_total_result0_o,
  output logic      [DW-1:0] channel_zero_clamped_result0_o,
  output logic      [DW-1:0] channel_one_clamped_result0_o,
  output logic      [DW-1:0] setpoint_total_result1_o,
  output logic      [DW-1:0] channel_zero_clamped_result1_o,
  output logic      [DW-1:0] channel_one_clamped_result1_o
);
  localparam int unsigned NI = SSS_NUM_INST;

  logic signed [DW-1:0] in0_q    [NI];
  logic signed [DW-1:0] in1_q    [NI];
  logic signed [DW-1:0] in2_q    [NI];
  logic signed [DW-1:0] ratio0_q [NI];
  logic signed [DW-1:0] ratio1_q [NI];
  logic signed [DW-1:0] div0_q   [NI];
  logic signed [DW-1:0] div1_q   [NI];
  logic        [1:0]    pos_q    [NI];
  logic        [DW-1:0] limit_q  [NI];
  logic signed [DW-1:0] total_w  [NI];
  logic signed [DW-1:0] ch0_w    [NI];
  logic signed [DW-1:0] ch1_w    [NI];

  logic        [31:0]   rdata_d;
  logic        [DW-1:0] wval;
  logic                 inst;
  logic        [5:0]    ofs;
  logic                 wr_go;

  // merge byte lanes of a 16-bit field
  function automatic logic [DW-1:0] merge(
    input logic [DW-1:0] old,
    input logic [31:0]   wd,
    input logic [3:0]    be
  );
    merge = old;
    if (be[0]) begin
      merge[7:0] = wd[7:0];
    end
    if (be[1]) begin
      merge[DW-1:8] = wd[DW-1:8];
    end
  endfunction

  assign inst  = address_i[6];
  assign ofs   = {address_i[5:2], 2'h0};
  assign wr_go = write_i && !waitrequest_o && ce_i;

  // one wait state: request seen, then answer with waitrequest low
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      waitrequest_o <= 1'b1;
    end else if (ce_i) begin
      if ((read_i || write_i) && waitrequest_o) begin
        waitrequest_o <= 1'b0;
      end else begin
        waitrequest_o <= 1'b1;
      end
    end
  end

  always_comb begin
    rdata_d = 32'h0;
    case (ofs)
      SSS_OFS_IN0:    rdata_d = {16'h0, in0_q[inst]};
      SSS_OFS_IN1:    rdata_d = {16'h0, in1_q[inst]};
      SSS_OFS_IN2:    rdata_d = {16'h0, in2_q[inst]};
      SSS_OFS_RATIO0: rdata_d = {16'h0, ratio0_q[inst]};
      SSS_OFS_RATIO1: rdata_d = {16'h0, ratio1_q[inst]};
      SSS_OFS_DIV0:   rdata_d = {16'h0, div0_q[inst]};
      SSS_OFS_DIV1:   rdata_d = {16'h0, div1_q[inst]};
      SSS_OFS_SIGN:   rdata_d = {30'h0, pos_q[inst]};
      SSS_OFS_LIMIT:  rdata_d = {16'h0, limit_q[inst]};
      SSS_OFS_TOTAL:  rdata_d = {16'h0, total_w[inst]};
      SSS_OFS_CH0:    rdata_d = {16'h0, ch0_w[inst]};
      SSS_OFS_CH1:    rdata_d = {16'h0, ch1_w[inst]};
      default:        rdata_d = 32'h0;
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      readdata_o <= 32'h0;
    end else if (ce_i) begin
      if (read_i && waitrequest_o) begin
        readdata_o <= rdata_d;
      end
    end
  end

  // limit write saturates at 200 percent
  always_comb begin
    wval = merge(limit_q[inst], writedata_i, byteenable_i);
    if (wval > SSS_LIMIT_MAX) begin
      wval = SSS_LIMIT_MAX;
    end
  end

  // scaling, sign and limit settings
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < NI; i++) begin
        ratio0_q[i] <= SSS_RATIO_RST;
        ratio1_q[i] <= SSS_RATIO_RST;
        div0_q[i]   <= SSS_DIV_RST;
        div1_q[i]   <= SSS_DIV_RST;
        pos_q[i]    <= SSS_SIGN_RST;
        limit_q[i]  <= SSS_LIMIT_RST;
      end
    end else if (wr_go) begin
      case (ofs)
        SSS_OFS_RATIO0: begin
          ratio0_q[inst] <= merge(ratio0_q[inst], writedata_i,
                                  byteenable_i);
        end
        SSS_OFS_RATIO1: begin
          ratio1_q[inst] <= merge(ratio1_q[inst], writedata_i,
                                  byteenable_i);
        end
        SSS_OFS_DIV0: begin
          div0_q[inst] <= merge(div0_q[inst], writedata_i, byteenable_i);
        end
        SSS_OFS_DIV1: begin
          div1_q[inst] <= merge(div1_q[inst], writedata_i, byteenable_i);
        end
        SSS_OFS_SIGN: begin
          if (byteenable_i[0]) begin
            pos_q[inst] <= writedata_i[1:0];
          end
        end
        SSS_OFS_LIMIT: begin
          limit_q[inst] <= wval;
        end
        default: begin
        end
      endcase
    end
  end

  // channel inputs written from the bus
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < NI; i++) begin
        in0_q[i] <= '0;
        in1_q[i] <= '0;
        in2_q[i] <= '0;
      end
    end else if (wr_go) begin
      case (ofs)
        SSS_OFS_IN0: begin
          in0_q[inst] <= merge(in0_q[inst], writedata_i, byteenable_i);
        end
        SSS_OFS_IN1: begin
          in1_q[inst] <= merge(in1_q[inst], writedata_i, byteenable_i);
        end
        SSS_OFS_IN2: begin
          in2_q[inst] <= merge(in2_q[inst], writedata_i, byteenable_i);
        end
        default: begin
        end
      endcase
    end
  end

  // two independent summing instances
  for (genvar g = 0; g < NI; g++) begin : g_unit
    sss_sum_unit #(
      .DW (DW)
    ) u_unit (
      .clock_i  (clock_i),
      .rst_i    (rst_i),
      .ce_i     (ce_i),
      .in0_i    (in0_q[g]),
      .in1_i    (in1_q[g]),
      .in2_i    (in2_q[g]),
      .ratio0_i (ratio0_q[g]),
      .ratio1_i (ratio1_q[g]),
      .div0_i   (div0_q[g]),
      .div1_i   (div1_q[g]),
      .pos0_i   (pos_q[g][0]),
      .pos1_i   (pos_q[g][1]),
      .limit_i  (limit_q[g]),
      .total_o  (total_w[g]),
      .ch0_o    (ch0_w[g]),
      .ch1_o    (ch1_w[g])
    );
  end

  assign setpoint_total_result0_o       = total_w[0];
  assign channel_zero_clamped_result0_o = ch0_w[0];
  assign channel_one_clamped_result0_o  = ch1_w[0];
  assign setpoint_total_result1_o       = total_w[1];
  assign channel_zero_clamped_result1_o = ch0_w[1];
  assign channel_one_clamped_result1_o  = ch1_w[1];
endmodule

/* File: sss_top_assertions.sv */
// bus handshake and result bound checks of the top
`timescale 1ns/10ps
module sss_top_assertions
  import sss_pkg::*;
#(
  parameter int unsigned DW = SSS_DW
) (
  input wire logic          clock_i,
  input wire logic          rst_i,
  input wire logic          ce_i,
  input wire logic [6:0]    address_i,
  input wire logic          read_i,
  input wire logic          write_i,
  input wire logic [31:0]   readdata_o,
  input wire logic          waitrequest_o,
  input wire logic [DW-1:0] setpoint_total_result0_o,
  input wire logic [DW-1:0] channel_zero_clamped_result0_o,
  input wire logic [DW-1:0] setpoint_total_result1_o
);
  function automatic logic [DW-1:0] mag(logic [DW-1:0] v);
    return v[DW-1] ? '0 - v : v;
  endfunction
  logic pend0_q;
  logic pend1_q;
  // a landed write shows on the result at the next enabled edge
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pend0_q <= 1'b0;
      pend1_q <= 1'b0;
    end else if (ce_i) begin
      pend0_q <= write_i && !waitrequest_o && !address_i[6];
      pend1_q <= write_i && !waitrequest_o && address_i[6];
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  property p_ack_once;
    !waitrequest_o && ce_i |=> waitrequest_o;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("wait low two cycles");
  property p_req_ack;
    (read_i || write_i) && waitrequest_o && ce_i |=> !waitrequest_o;
  endproperty
  a_req_ack: assert property (p_req_ack)
    else $error("request not answered");
  property p_unmap;
    read_i && !waitrequest_o && address_i[5:2] > 4'hb |-> readdata_o == '0;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped word not zero");
  property p_tot0;
    mag(setpoint_total_result0_o) <= SSS_LIMIT_MAX;
  endproperty
  a_tot0: assert property (p_tot0)
    else $error("total 0 outside band");
  property p_ch0;
    mag(channel_zero_clamped_result0_o) <= SSS_LIMIT_MAX;
  endproperty
  a_ch0: assert property (p_ch0)
    else $error("channel 0 outside band");
  property p_tot1;
    mag(setpoint_total_result1_o) <= SSS_LIMIT_MAX;
  endproperty
  a_tot1: assert property (p_tot1)
    else $error("total 1 outside band");
  property p_hold0;
    $changed(setpoint_total_result0_o) |->
      $past(pend0_q && ce_i);
  endproperty
  a_hold0: assert property (p_hold0)
    else $error("total 0 moved without write");
  property p_hold1;
    $changed(setpoint_total_result1_o) |->
      $past(pend1_q && ce_i);
  endproperty
  a_hold1: assert property (p_hold1)
    else $error("total 1 moved without write");
  c_wr: cover property (write_i && !waitrequest_o);
  c_rd: cover property (read_i && !waitrequest_o);
  c_t1: cover property ($changed(setpoint_total_result1_o));
  c_frz: cover property (!ce_i && pend1_q);
endmodule
bind sss_top sss_top_assertions #(.DW(DW)) u_chk (
  .clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i), .address_i(address_i),
  .read_i(read_i), .write_i(write_i), .readdata_o(readdata_o),
  .waitrequest_o(waitrequest_o),
  .setpoint_total_result0_o(setpoint_total_result0_o),
  .channel_zero_clamped_result0_o(channel_zero_clamped_result0_o),
  .setpoint_total_result1_o(setpoint_total_result1_o));

/* File: tb_setpoint_sum_scaler.sv */
// testbench of the setpoint sum scaler
`timescale 1ns/10ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin n_fail++; \
  $display("mismatch %s exp %h got %h", n, e, a); end end
module tb_setpoint_sum_scaler;
  import sss_pkg::*;
  logic        clock_i = 0, rst_i = 1, read_i = 0, write_i = 0, ce_i = 1;
  logic [6:0]  address_i = '0;
  logic [31:0] writedata_i = '0, readdata_o, rd;
  logic        waitrequest_o;
  logic [15:0] t0, c00, c10, t1, c01, c11, s0, s1;
  int          n_fail = 0, checked = 0;
  always #12.5 clock_i = ~clock_i;
  sss_top u_dut (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i),
    .address_i(address_i), .read_i(read_i), .write_i(write_i),
    .byteenable_i(4'hf), .writedata_i(writedata_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .setpoint_total_result0_o(t0), .channel_zero_clamped_result0_o(c00),
    .channel_one_clamped_result0_o(c10), .setpoint_total_result1_o(t1),
    .channel_zero_clamped_result1_o(c01),
    .channel_one_clamped_result1_o(c11));
  sss_downstream_model u_sink (.clock_i(clock_i), .total0_i(t0),
    .total1_i(t1), .seen0_o(s0), .seen1_o(s1));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one avalon transfer, then two cycles for results to settle
  task automatic req(input logic [6:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge clock_i);
    address_i <= a;
    writedata_i <= d;
    write_i <= w;
    read_i <= !w;
    do begin
      @(posedge clock_i);
    end while (waitrequest_o !== 1'b0);
    rd = readdata_o;
    write_i <= 1'b0;
    read_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    #1;
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [31:0] e);
    req(a, 1'b0, 32'h0);
    `CHK("readdata", e, rd)
  endtask
  initial begin
    repeat (2000) @(posedge clock_i);
    n_fail++;
    finish_test;
  end
  initial begin
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    rdchk(7'h0c, {16'h0, SSS_RATIO_RST});
    rdchk(7'h58, {16'h0, SSS_DIV_RST});
    rdchk(7'h1c, {30'h0, SSS_SIGN_RST});
    rdchk(7'h20, {16'h0, SSS_LIMIT_RST});
    $display("test reset done");
    req(7'h00, 1, 32'h1388);
    req(7'h0c, 1, 32'h4e20);
    req(7'h04, 1, 32'h0bb8);
    req(7'h1c, 1, 32'h1);
    req(7'h08, 1, 32'h07d0);
    `CHK("ch0", 16'h2710, c00)
    `CHK("ch1", 16'hf448, c10)
    `CHK("total", 16'h2328, t0)
    rdchk(7'h24, 32'h2328);
    $display("test scale done");
    req(7'h00, 1, 32'h1f40);
    req(7'h08, 1, 32'h1770);
    `CHK("ch0", SSS_LIMIT_RST, c00)
    `CHK("total", SSS_LIMIT_RST, t0)
    req(7'h04, 1, 32'h4e20);
    `CHK("ch1", 16'h0 - SSS_LIMIT_RST, c10)
    `CHK("total", 16'h1770, t0)
    rdchk(7'h28, {16'h0, SSS_LIMIT_RST});
    $display("test clamp done");
    req(7'h14, 1, 32'h0);
    `CHK("ch0", 16'h0, c00)
    `CHK("total", 16'hee6c, t0)
    req(7'h20, 1, 32'h7530);
    rdchk(7'h20, {16'h0, SSS_LIMIT_MAX});
    `CHK("ch1", 16'h0 - SSS_LIMIT_MAX, c10)
    `CHK("total", 16'hc950, t0)
    $display("test limit done");
    req(7'h48, 1, 32'hfe0c);
    `CHK("total1", 16'hfe0c, s1)
    `CHK("total0", 16'hc950, s0)
    `CHK("ch0 1", 16'h0, c01)
    `CHK("ch1 1", 16'h0, c11)
    rdchk(7'h70, 32'h0);
    req(7'h24, 1, 32'h1234);
    rdchk(7'h24, 32'hc950);
    $display("test instance done");
    req(7'h44, 1, 32'hfc17);
    req(7'h50, 1, 32'h3a98);
    req(7'h58, 1, 32'h4e20);
    req(7'h5c, 1, 32'h1);
    `CHK("ch1 1", 16'h02ee, c11)
    `CHK("total1", 16'h00fa, t1)
    `CHK("total0", 16'hc950, t0)
    rdchk(7'h6c, 32'h2ee);
    $display("test ratio done");
    fork
      req(7'h48, 1, 32'h0064);
      begin
        do begin
          @(posedge clock_i);
        end while (waitrequest_o !== 1'b0);
        ce_i <= 1'b0;
        @(posedge clock_i);
        #1;
        `CHK("total1 frozen", 16'h00fa, t1)
        @(posedge clock_i);
        ce_i <= 1'b1;
      end
    join
    @(posedge clock_i);
    #1;
    `CHK("total1", 16'h0352, t1)
    $display("test enable done");
    finish_test;
  end
endmodule
